// ---- design/ics_clock_switcher.sv ----
// Purpose: glitch-free system clock source switching and oscillator start-up control
// Assumes: oscillator inputs are far slower than the 125 MHz core clock
// Notes: oscillators are sampled, so the output clock carries up to one core clock cycle of jitter
`timescale 1ns/1ns

// Summary of operation
// - on a select change, wait a falling edge of current clock, hold output low
// - while held low, count eight falling edges of new clock, then switch
// - leaving the low-frequency source for a main frequency: clear stable flag, start 4 ms delay
// - switching down to low-frequency source completes after handover, no delay
// - between two main frequencies: set stable flag after the handover
// - after wake-up or power-on, a CPU start-up delay precedes execution
// - waking into a main frequency adds 4 ms stabilisation before CPU start-up
// - entering a crystal mode counts 1024 oscillator cycles before use
// - CPU start-up delay lasts 5 to 10 us
// - secondary crystal oscillator runs only while its enable bit 3 is set
// - secondary oscillator keeps running through sleep and all mode changes
module ics_clock_switcher
  import ics_pkg::*;
#(
  parameter int STAB_COUNT = STAB_CYCLES,
  parameter logic [2:0] SEL_INIT = SEL_RESET
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // oscillator pins, index = select code
  input wire logic [7:0] osc_tap_in,
  input wire logic primary_osc_in,
  input wire logic [2:0] primary_mode,
  // core power state
  input wire logic sleep_req,
  // clock and core control
  output logic system_clock_out,
  output logic cpu_run,
  output logic secondary_osc_run
);

  typedef enum logic [1:0] {
    SW_RUN,
    SW_OST,
    SW_WAIT_CUR,
    SW_HOLD
  } ics_sw_state_e;

  typedef enum logic [2:0] {
    BT_STAB,
    BT_OST,
    BT_CPU,
    BT_RUN,
    BT_SLEEP
  } ics_boot_state_e;

  // pin synchronisers, third stage only for edge detection
  logic [8:0] src_s1_reg;
  logic [8:0] src_s2_reg;
  logic [8:0] src_s3_reg;
  logic [8:0] src_fall;

  always_ff @(posedge clk)
  begin
    src_s1_reg <= {primary_osc_in, osc_tap_in};
    src_s2_reg <= src_s1_reg;
    src_s3_reg <= src_s2_reg;
  end

  assign src_fall = src_s3_reg & ~src_s2_reg;

  // software registers
  logic [2:0] int_osc_freq_select_reg;
  logic [2:0] int_osc_freq_select_next;
  logic use_primary_reg;
  logic use_primary_next;
  logic [7:0] secondary_timer_control_reg;
  logic [7:0] secondary_timer_control_next;
  logic [7:0] reg_rdata_reg;
  logic [7:0] reg_rdata_next;

  // switch and boot state
  ics_sw_state_e sw_state_reg;
  ics_sw_state_e sw_state_next;
  ics_boot_state_e bt_state_reg;
  ics_boot_state_e bt_state_next;
  logic [3:0] cur_src_reg;
  logic [3:0] cur_src_next;
  logic [3:0] tgt_src_reg;
  logic [3:0] tgt_src_next;
  logic int_osc_freq_stable_reg;
  logic int_osc_freq_stable_next;
  logic ost_done_reg;
  logic ost_done_next;
  logic sys_clk_reg;
  logic sys_clk_next;
  logic cpu_run_reg;
  logic cpu_run_next;
  logic sec_run_reg;
  logic sec_run_next;

  // timers and counters
  logic hand_start;
  logic hand_done;
  logic ost_start;
  logic ost_done;
  logic stab_start;
  logic stab_done;
  logic stab_busy;
  logic cpu_start;
  logic cpu_done;
  logic [3:0] req_src;
  logic crystal_sel;
  logic sel_change;
  // wake into a crystal mode must rerun the start-up count
  logic ost_wake;
  // the timers cannot be started by reset itself, so the first cycle kicks them
  logic stab_start_all;
  logic cpu_start_all;
  logic boot_kick_reg;
  logic boot_kick_next;

  assign req_src = use_primary_reg ? SRC_PRIMARY : {1'b0, int_osc_freq_select_reg};
  assign crystal_sel = use_primary_reg && ics_is_crystal(primary_mode);
  assign sel_change = (req_src != cur_src_reg);

  ics_edge_counter #(.WIDTH(4)) u_handover (
    .clk(clk),
    .srst(srst),
    .start(hand_start),
    .edge_pulse(src_fall[tgt_src_reg]),
    .target(4'(HANDOVER_EDGES)),
    .busy(),
    .done(hand_done)
  );

  ics_edge_counter #(.WIDTH(11)) u_ost (
    .clk(clk),
    .srst(srst),
    .start(ost_start || ost_wake),
    .edge_pulse(src_fall[SRC_PRIMARY]),
    .target(11'(OST_EDGES)),
    .busy(),
    .done(ost_done)
  );

  ics_delay_timer #(.WIDTH(20)) u_stab (
    .clk(clk),
    .srst(srst),
    .start(stab_start_all),
    .load(20'(STAB_COUNT)),
    .busy(stab_busy),
    .done(stab_done)
  );

  ics_delay_timer #(.WIDTH(10)) u_cpu (
    .clk(clk),
    .srst(srst),
    .start(cpu_start_all),
    .load(10'(CPU_START_CYCLES)),
    .busy(),
    .done(cpu_done)
  );

  // register port
  always_comb
  begin
    int_osc_freq_select_next = int_osc_freq_select_reg;
    use_primary_next = use_primary_reg;
    secondary_timer_control_next = secondary_timer_control_reg;
    reg_rdata_next = 8'h00;
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_OSC_CTRL:
        begin
          int_osc_freq_select_next = reg_wdata[CTRL_SEL_LSB +: 3];
          use_primary_next = reg_wdata[CTRL_PRIMARY_BIT];
        end
        ADDR_SEC_TIMER_CTRL: secondary_timer_control_next = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_OSC_CTRL:
        begin
          reg_rdata_next[CTRL_SEL_LSB +: 3] = int_osc_freq_select_reg;
          reg_rdata_next[CTRL_PRIMARY_BIT] = use_primary_reg;
        end
        ADDR_OSC_STATUS:
        begin
          reg_rdata_next[STAT_STABLE_BIT] = int_osc_freq_stable_reg;
          reg_rdata_next[STAT_SWITCHING_BIT] = (sw_state_reg != SW_RUN);
          reg_rdata_next[STAT_CPU_READY_BIT] = cpu_run_reg;
          reg_rdata_next[STAT_OST_DONE_BIT] = ost_done_reg;
          reg_rdata_next[STAT_CUR_LSB +: 4] = cur_src_reg;
        end
        ADDR_SEC_TIMER_CTRL: reg_rdata_next = secondary_timer_control_reg;
        default: reg_rdata_next = 8'h00;
      endcase
    end
  end

  // source switching; only runs while the core is awake
  always_comb
  begin
    sw_state_next = sw_state_reg;
    cur_src_next = cur_src_reg;
    tgt_src_next = tgt_src_reg;
    hand_start = 1'b0;
    ost_start = 1'b0;
    sys_clk_next = src_s2_reg[cur_src_reg];
    unique case (sw_state_reg)
      SW_RUN:
        if (bt_state_reg == BT_RUN && sel_change)
        begin
          tgt_src_next = req_src;
          if (req_src == SRC_PRIMARY && crystal_sel && !ost_done_reg)
          begin
            ost_start = 1'b1;
            sw_state_next = SW_OST;
          end
          else
            sw_state_next = SW_WAIT_CUR;
        end
      SW_OST:
        if (ost_done)
          sw_state_next = SW_WAIT_CUR;
      SW_WAIT_CUR:
        if (src_fall[cur_src_reg])
        begin
          sys_clk_next = 1'b0;
          hand_start = 1'b1;
          sw_state_next = SW_HOLD;
        end
      SW_HOLD:
      begin
        sys_clk_next = 1'b0;
        if (hand_done)
        begin
          cur_src_next = tgt_src_reg;
          sw_state_next = SW_RUN;
        end
      end
    endcase
  end

  // stable flag, start-up sequence and secondary oscillator
  always_comb
  begin
    bt_state_next = bt_state_reg;
    int_osc_freq_stable_next = int_osc_freq_stable_reg;
    ost_done_next = ost_done_reg;
    stab_start = 1'b0;
    cpu_start = 1'b0;
    ost_wake = 1'b0;
    cpu_run_next = 1'b0;
    // secondary oscillator follows only its enable bit, sleep has no say
    sec_run_next = secondary_timer_control_reg[SEC_OSC_ENABLE_BIT];
    if (ost_done)
      ost_done_next = 1'b1;
    if (!use_primary_reg)
      ost_done_next = 1'b0;
    if (sw_state_reg == SW_HOLD && hand_done)
    begin
      if (cur_src_reg[2:0] == SEL_LOW_FREQ_RC && cur_src_reg != SRC_PRIMARY
          && tgt_src_reg != SRC_PRIMARY && tgt_src_reg[2:0] != SEL_LOW_FREQ_RC)
      begin
        int_osc_freq_stable_next = 1'b0;
        stab_start = 1'b1;
      end
      else if (tgt_src_reg[2:0] == SEL_LOW_FREQ_RC && tgt_src_reg != SRC_PRIMARY)
        int_osc_freq_stable_next = 1'b0;
      else if (tgt_src_reg != SRC_PRIMARY)
        int_osc_freq_stable_next = 1'b1;
    end
    if (stab_done && bt_state_reg == BT_RUN)
      int_osc_freq_stable_next = 1'b1;
    unique case (bt_state_reg)
      BT_STAB:
        if (stab_done)
        begin
          int_osc_freq_stable_next = 1'b1;
          cpu_start = 1'b1;
          bt_state_next = BT_CPU;
        end
      BT_OST:
        if (ost_done)
        begin
          cpu_start = 1'b1;
          bt_state_next = BT_CPU;
        end
      BT_CPU:
        if (cpu_done)
        begin
          cpu_run_next = 1'b1;
          bt_state_next = BT_RUN;
        end
      BT_RUN:
      begin
        cpu_run_next = 1'b1;
        if (sleep_req && sw_state_reg == SW_RUN)
        begin
          cpu_run_next = 1'b0;
          bt_state_next = BT_SLEEP;
        end
      end
      BT_SLEEP:
        if (!sleep_req)
        begin
          // wake-up path picks the delay that the running source needs
          if (cur_src_reg == SRC_PRIMARY && crystal_sel)
          begin
            ost_wake = 1'b1;
            bt_state_next = BT_OST;
          end
          else if (cur_src_reg[2:0] != SEL_LOW_FREQ_RC && cur_src_reg != SRC_PRIMARY)
          begin
            int_osc_freq_stable_next = 1'b0;
            stab_start = 1'b1;
            bt_state_next = BT_STAB;
          end
          else
          begin
            cpu_start = 1'b1;
            bt_state_next = BT_CPU;
          end
        end
      default: bt_state_next = BT_STAB;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      int_osc_freq_select_reg <= SEL_INIT;
      use_primary_reg <= 1'b0;
      secondary_timer_control_reg <= SEC_CTRL_RESET;
      reg_rdata_reg <= 8'h00;
      sw_state_reg <= SW_RUN;
      cur_src_reg <= {1'b0, SEL_INIT};
      tgt_src_reg <= {1'b0, SEL_INIT};
      // power-on: a main frequency needs its stabilisation first
      bt_state_reg <= (SEL_INIT == SEL_LOW_FREQ_RC) ? BT_CPU : BT_STAB;
      int_osc_freq_stable_reg <= 1'b0;
      ost_done_reg <= 1'b0;
      sys_clk_reg <= 1'b0;
      cpu_run_reg <= 1'b0;
      sec_run_reg <= 1'b0;
    end
    else
    begin
      int_osc_freq_select_reg <= int_osc_freq_select_next;
      use_primary_reg <= use_primary_next;
      secondary_timer_control_reg <= secondary_timer_control_next;
      reg_rdata_reg <= reg_rdata_next;
      sw_state_reg <= sw_state_next;
      cur_src_reg <= cur_src_next;
      tgt_src_reg <= tgt_src_next;
      bt_state_reg <= bt_state_next;
      int_osc_freq_stable_reg <= int_osc_freq_stable_next;
      ost_done_reg <= ost_done_next;
      sys_clk_reg <= sys_clk_next;
      cpu_run_reg <= cpu_run_next;
      sec_run_reg <= sec_run_next;
    end
  end

  assign boot_kick_next = 1'b0;
  always_ff @(posedge clk)
  begin
    if (srst)
      boot_kick_reg <= 1'b1;
    else
      boot_kick_reg <= boot_kick_next;
  end

  assign stab_start_all = stab_start || (boot_kick_reg && bt_state_reg == BT_STAB);
  assign cpu_start_all = cpu_start || (boot_kick_reg && bt_state_reg == BT_CPU);

  assign reg_rdata = reg_rdata_reg;
  assign system_clock_out = sys_clk_reg;
  assign cpu_run = cpu_run_reg;
  assign secondary_osc_run = sec_run_reg;

endmodule : ics_clock_switcher

// ---- design/ics_pkg.sv ----
// Purpose: shared constants for the internal oscillator clock switcher
// Assumes: 125 MHz core clock, 8-bit register port with 4-bit address
// Notes: oscillator taps are indexed by the frequency select code
package ics_pkg;

  // core clock
  localparam int CLK_PERIOD_NS = 8;

  // timing figures in their own units, and the derived cycle counts
  localparam int STAB_TIME_US = 4000;
  localparam int STAB_CYCLES = (STAB_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int CPU_START_MIN_NS = 5000;
  localparam int CPU_START_MAX_NS = 10000;
  localparam int CPU_START_CYCLES = (CPU_START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HANDOVER_EDGES = 8;
  localparam int OST_EDGES = 1024;

  // register offsets
  localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
  localparam logic [3:0] ADDR_OSC_STATUS = 4'h1;
  localparam logic [3:0] ADDR_SEC_TIMER_CTRL = 4'h2;

  // osc control fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_PRIMARY_BIT = 4;
  // osc status fields
  localparam int STAT_STABLE_BIT = 0;
  localparam int STAT_SWITCHING_BIT = 1;
  localparam int STAT_CPU_READY_BIT = 2;
  localparam int STAT_OST_DONE_BIT = 3;
  localparam int STAT_CUR_LSB = 4;
  // secondary timer control fields
  localparam int SEC_OSC_ENABLE_BIT = 3;

  // reset values and the low-frequency select code
  localparam logic [2:0] SEL_RESET = 3'h6;
  localparam logic [2:0] SEL_LOW_FREQ_RC = 3'h0;
  localparam logic [7:0] SEC_CTRL_RESET = 8'h00;

  // source index of the primary (external) oscillator, after the 8 internal taps
  localparam logic [3:0] SRC_PRIMARY = 4'h8;

  // primary oscillator configuration
  typedef enum logic [2:0] {
    low_power_crystal_mode,
    standard_crystal_mode,
    high_speed_crystal_mode,
    external_clock_input_mode,
    external_resistor_cap_mode
  } ics_primary_mode_e;

  function automatic logic ics_is_crystal(input logic [2:0] mode);
    ics_is_crystal = (mode == low_power_crystal_mode) || (mode == standard_crystal_mode)
      || (mode == high_speed_crystal_mode);
  endfunction : ics_is_crystal

endpackage : ics_pkg

// ---- design/ics_edge_counter.sv ----
// Purpose: counts edge pulses from a synchronised oscillator after a start
// Assumes: edge_pulse is one core cycle per oscillator edge
// Notes: done is a one-cycle pulse in the cycle after the edge that reaches the target
`timescale 1ns/1ns
module ics_edge_counter #(
  parameter int WIDTH = 11
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic start,
  input wire logic edge_pulse,
  input wire logic [WIDTH-1:0] target,
  // status
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (start)
    begin
      cnt_next = '0;
      busy_next = 1'b1;
    end
    else if (busy_reg && edge_pulse)
    begin
      cnt_next = cnt_reg + WIDTH'(1);
      if (cnt_reg + WIDTH'(1) == target)
      begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;

endmodule : ics_edge_counter

// ---- design/ics_delay_timer.sv ----
// Purpose: one-shot delay measured in core clock cycles
// Assumes: load is at least 1
// Notes: done pulses once, load plus one cycles after the start cycle
`timescale 1ns/1ns
module ics_delay_timer #(
  parameter int WIDTH = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic start,
  input wire logic [WIDTH-1:0] load,
  // status
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic done_reg;
  logic done_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (start)
      cnt_next = load;
    else if (cnt_reg != '0)
    begin
      cnt_next = cnt_reg - WIDTH'(1);
      done_next = (cnt_reg == WIDTH'(1));
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign busy = (cnt_reg != '0);
  assign done = done_reg;

endmodule : ics_delay_timer

// ---- testbench/ics_osc_model.sv ----
// Purpose: free-running internal oscillator taps and external crystal for the switcher bench
// Assumes: every half period is several core clock cycles long
// Notes: oscillators never stop, so the switcher sees them toggle at all times
`timescale 1ns/1ns
module ics_osc_model #(
  parameter int LF_HALF_NS = 160,
  parameter int HF_HALF_NS = 40,
  parameter int HF_STEP_NS = 4,
  parameter int PRI_HALF_NS = 44
) (
  // internal taps, index = select code
  output logic [7:0] osc_tap,
  // external crystal
  output logic primary_osc
);
  for (genvar i = 0; i < 8; i++)
  begin : g_tap
    logic t;
    // staggered start so no two taps share a phase
    initial
    begin
      t = 1'b0;
      #(3 * i + 1);
      forever #((i == 0) ? LF_HALF_NS : HF_HALF_NS + HF_STEP_NS * i) t = ~t;
    end
    assign osc_tap[i] = t;
  end

  initial
  begin
    primary_osc = 1'b0;
    #7;
    forever #(PRI_HALF_NS) primary_osc = ~primary_osc;
  end
endmodule : ics_osc_model

// ---- testbench/ics_clock_switcher_sva.sv ----
// Purpose: port-level checks for the oscillator clock switcher
// Assumes: bound to the top module, single core clock domain
// Notes: start-up bounds are counted from reset release or sleep exit
`timescale 1ns/1ns
module ics_clock_switcher_sva
  import ics_pkg::*;
#(
  parameter int STAB_COUNT = STAB_CYCLES,
  parameter logic [2:0] SEL_INIT = SEL_RESET
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // core and clock
  input wire logic sleep_req,
  input wire logic system_clock_out,
  input wire logic cpu_run,
  input wire logic secondary_osc_run
);
  localparam int CPU_MAX = CPU_START_MAX_NS / CLK_PERIOD_NS;
  logic [19:0] awake_reg;
  logic [19:0] awake_next;
  logic booted_reg;
  logic booted_next;

  // awake time saturates so a long run cannot wrap into a false short delay
  always_comb
  begin
    awake_next = awake_reg;
    booted_next = booted_reg | cpu_run;
    if (srst || sleep_req)
      awake_next = 20'h00000;
    else if (awake_reg != 20'hfffff)
      awake_next = awake_reg + 20'h00001;
    if (srst)
      booted_next = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    awake_reg <= awake_next;
    booted_reg <= booted_next;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_SEC_TIMER_CTRL |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  a_sec_readback: assert property ((reg_wr && reg_addr == ADDR_SEC_TIMER_CTRL) ##1
    (reg_rd && !reg_wr && reg_addr == ADDR_SEC_TIMER_CTRL) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("secondary control readback differs");
  a_ctrl_readback: assert property ((reg_wr && reg_addr == ADDR_OSC_CTRL) ##1
    (reg_rd && !reg_wr && reg_addr == ADDR_OSC_CTRL)
    |=> (reg_rdata & 8'h17) == ($past(reg_wdata, 2) & 8'h17))
    else $error("control readback differs");
  a_sec_run_on: assert property (reg_wr && reg_addr == ADDR_SEC_TIMER_CTRL && reg_wdata[3]
    |-> ##[1:2] secondary_osc_run)
    else $error("secondary oscillator not started by enable");
  a_sec_run_off: assert property (reg_wr && reg_addr == ADDR_SEC_TIMER_CTRL && !reg_wdata[3]
    |-> ##[1:2] !secondary_osc_run)
    else $error("secondary oscillator not stopped by enable clear");
  a_sec_run_hold: assert property ($changed(secondary_osc_run)
    |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("secondary oscillator changed without a write");
  a_cpu_sleep_off: assert property (sleep_req [*4] |-> !cpu_run)
    else $error("core runs while asleep");
  a_cpu_start_win: assert property ($rose(cpu_run)
    |-> awake_reg >= CPU_START_CYCLES && awake_reg <= STAB_COUNT + CPU_MAX + 40)
    else $error("core start-up delay out of range");
  a_boot_delay: assert property ($rose(cpu_run) && !booted_reg && SEL_INIT != SEL_LOW_FREQ_RC
    |-> awake_reg >= STAB_COUNT + CPU_START_CYCLES)
    else $error("boot into main tap skipped stabilisation");
  a_reset_quiet: assert property (disable iff (1'b0) $past(srst)
    |-> !system_clock_out && !cpu_run && !secondary_osc_run && reg_rdata == 8'h00)
    else $error("outputs active during reset");

  c_cpu_start: cover property ($rose(cpu_run));
  c_sleep_sec: cover property (sleep_req && secondary_osc_run);
  c_status_rd: cover property (reg_rd && reg_addr == ADDR_OSC_STATUS);
endmodule : ics_clock_switcher_sva

bind ics_clock_switcher ics_clock_switcher_sva #(.STAB_COUNT(STAB_COUNT), .SEL_INIT(SEL_INIT)) u_sva (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
  .system_clock_out(system_clock_out), .cpu_run(cpu_run), .secondary_osc_run(secondary_osc_run)
);

// ---- testbench/ics_clock_switcher_test.sv ----
// Purpose: self-checking bench for the oscillator clock switcher
// Assumes: shortened stabilisation count, oscillators from the model
// Notes: every task starts and ends just after a rising edge
`timescale 1ns/1ns
module ics_clock_switcher_test
  import ics_pkg::*;
;
  localparam int STAB = 200;
  localparam int LF_HALF = 160;
  localparam int HF_HALF = 40;
  localparam int HF_STEP = 4;
  localparam int PRI_HALF = 44;
  localparam int CPU_MAX = CPU_START_MAX_NS / CLK_PERIOD_NS;
  localparam int LIMIT = 40000;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rd;
    logic run;
  } ics_row_s;
  logic clk, srst, reg_wr, reg_rd, primary_osc_in, sleep_req;
  logic system_clock_out, cpu_run, secondary_osc_run;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, osc_tap_in, d, st;
  logic [2:0] primary_mode;
  int error_cnt, checks_done, cyc, n;
  ics_row_s rows [6] = '{'{4'h2, 8'h08, 8'h08, 1'b1}, '{4'h2, 8'hf7, 8'hf7, 1'b0},
    '{4'h2, 8'hff, 8'hff, 1'b1}, '{4'hf, 8'ha5, 8'h00, 1'b1}, '{4'h3, 8'h5a, 8'h00, 1'b1},
    '{4'h2, 8'h00, 8'h00, 1'b0}};

  ics_clock_switcher #(.STAB_COUNT(STAB), .SEL_INIT(SEL_RESET)) DUT (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_tap_in(osc_tap_in),
    .primary_osc_in(primary_osc_in), .primary_mode(primary_mode), .sleep_req(sleep_req),
    .system_clock_out(system_clock_out), .cpu_run(cpu_run), .secondary_osc_run(secondary_osc_run)
  );
  ics_osc_model #(.LF_HALF_NS(LF_HALF), .HF_HALF_NS(HF_HALF), .HF_STEP_NS(HF_STEP),
    .PRI_HALF_NS(PRI_HALF)) u_osc (.osc_tap(osc_tap_in), .primary_osc(primary_osc_in));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic wrap_up;
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  // a hang anywhere ends the run as a mismatch
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int v, input int lo, input int hi);
    checks_done++;
    if (v < lo || v > hi)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask : chk_rng

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
    @(posedge clk);
  endtask : rd

  // status polling costs two cycles a read
  task automatic poll(input logic [7:0] mask, input logic [7:0] val, input int max);
    n = 0;
    do
    begin
      rd(ADDR_OSC_STATUS, st);
      n += 2;
    end
    while ((st & mask) !== val && n < max);
  endtask : poll

  task automatic wait_run(input int lo, input int hi);
    n = 0;
    while (cpu_run !== 1'b1 && n < hi + 50)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    chk_rng(n, lo, hi);
  endtask : wait_run

  // longest low stretch of the output must span the eight-edge handover
  task automatic switch_to(input logic [2:0] sel, input int new_half, input int old_half);
    int run;
    int mx;
    run = 0;
    mx = 0;
    n = 0;
    wr(ADDR_OSC_CTRL, {5'h00, sel});
    while (!(system_clock_out === 1'b1 && mx >= 14 * new_half / 8 - 2) && n < 3000)
    begin
      @(negedge clk);
      n++;
      run = (system_clock_out === 1'b0) ? run + 1 : 0;
      mx = (run > mx) ? run : mx;
    end
    @(posedge clk);
    chk_rng(mx, 14 * new_half / 8 - 2, (2 * old_half + 18 * new_half) / 8 + 12);
    rd(ADDR_OSC_STATUS, st);
    chk({st[7:4], st[STAT_SWITCHING_BIT]}, {1'b0, sel, 1'b0});
  endtask : switch_to

  initial
  begin
    srst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_req = 1'b0;
    primary_mode = low_power_crystal_mode;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    repeat (10) @(posedge clk);
    chk({system_clock_out, cpu_run, secondary_osc_run}, 3'h0);
    srst <= 1'b0;
    wait_run(STAB + CPU_START_CYCLES, STAB + CPU_MAX + 40);
    rd(ADDR_OSC_STATUS, st);
    chk({st[7:4], st[STAT_STABLE_BIT]}, {1'b0, SEL_RESET, 1'b1});
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, d);
      chk(d, rows[i].rd);
      chk(secondary_osc_run, rows[i].run);
    end
    rd(ADDR_OSC_CTRL, d);
    chk(d & 8'h17, {5'h00, SEL_RESET});
    switch_to(3'h5, HF_HALF + 5 * HF_STEP, HF_HALF + 6 * HF_STEP);
    chk(st[STAT_STABLE_BIT], 1'b1);
    switch_to(SEL_LOW_FREQ_RC, LF_HALF, HF_HALF + 5 * HF_STEP);
    switch_to(3'h6, HF_HALF + 6 * HF_STEP, LF_HALF);
    chk(st[STAT_STABLE_BIT], 1'b0);
    poll(8'h01, 8'h01, 1000);
    chk_rng(n, STAB - 20, STAB + 10);
    wr(ADDR_SEC_TIMER_CTRL, 8'h08);
    repeat (64) @(posedge clk);
    sleep_req <= 1'b1;
    repeat (20) @(posedge clk);
    chk({cpu_run, secondary_osc_run}, 2'b01);
    sleep_req <= 1'b0;
    wait_run(STAB + CPU_START_CYCLES, STAB + CPU_MAX + 40);
    chk(secondary_osc_run, 1'b1);
    switch_to(SEL_LOW_FREQ_RC, LF_HALF, HF_HALF + 6 * HF_STEP);
    wr(ADDR_OSC_CTRL, 8'h10);
    rd(ADDR_OSC_CTRL, d);
    chk(d & 8'h17, 8'h10);
    poll(8'h08, 8'h08, 20000);
    chk_rng(n, OST_EDGES * 2 * PRI_HALF / 8 - 20, (OST_EDGES + 2) * 2 * PRI_HALF / 8 + 30);
    poll(8'h02, 8'h00, 3000);
    chk(st[7:4], SRC_PRIMARY);
    // second reset mid-run must clear the stored enable
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({system_clock_out, cpu_run, secondary_osc_run}, 3'h0);
    @(posedge clk);
    srst <= 1'b0;
    rd(ADDR_SEC_TIMER_CTRL, d);
    chk(d, SEC_CTRL_RESET);
    wrap_up();
  end
endmodule : ics_clock_switcher_test
